// [design/port_clock_gating_pkg.sv]
// register map, field layout and shared types for the port clock gating block
// assumes a plain single-cycle register port on the system clock
package port_clock_gating_pkg;

  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int NUM_PORTS  = 5;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RUN_GATE_OFS   = 12'h108;
  localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h118;
  localparam logic [ADDR_W-1:0] DEEP_GATE_OFS  = 12'h128;
  localparam logic [ADDR_W-1:0] DS_SRC_OFS     = 12'h144;
  localparam logic [ADDR_W-1:0] VFY_CLR_OFS    = 12'h150;
  localparam logic [ADDR_W-1:0] REG_RST_OFS    = 12'h160;
  localparam logic [ADDR_W-1:0] RUN_CFG_OFS    = 12'h060;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS   = 12'h170;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS   = 12'h174;

  // ---------------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int AUTO_GATE_BIT  = 0;
  localparam int OSC_OVR_BIT    = 0;
  localparam int VFY_CLR_BIT    = 0;
  localparam int REG_RST_BIT    = 0;
  localparam logic [NUM_PORTS-1:0] GATE_RST = 5'h00;
  localparam logic [DATA_W-1:0]    ZERO_WORD = 32'h0000_0000;

  // interrupt status bit positions
  localparam int EV_FAULT   = 0;
  localparam int EV_VERIFY  = 1;
  localparam int EV_WAKE    = 2;
  localparam int NUM_EVENTS = 3;

  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_SLEEP = 2'b01,
    PM_DEEP  = 2'b11
  } power_mode_type;

  typedef enum logic [1:0] {
    SRC_MAIN     = 2'b00,
    SRC_INTERNAL = 2'b01,
    SRC_BACKUP   = 2'b11
  } clk_src_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

  typedef struct packed {
    logic [NUM_PORTS-1:0] sel;
    logic                 rd;
    logic                 wr;
  } port_access_type;

endpackage : port_clock_gating_pkg

// [design/port_clock_gating_sysctl.sv]
// port clock gating, deep-sleep clock source override, verify clear and
// regulator reset enable, all in one system-control slice
// assumes power mode, wake and fault inputs are on sys_clk_i already,
// except the regulator status, which comes from an analog pin
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module port_clock_gating_sysctl
  import port_clock_gating_pkg::*;
(
  input  wire logic                                      sys_clk_i,
  input  wire logic                                      reset_n_i,
  input  wire port_clock_gating_pkg::reg_req_type        reg_req_i,
  output logic [port_clock_gating_pkg::DATA_W-1:0]       reg_rdata_o,
  input  wire port_clock_gating_pkg::power_mode_type     power_mode_i,
  input  wire logic                                      deep_wake_i,
  input  wire port_clock_gating_pkg::clk_src_type        run_src_i,
  input  wire logic                                      verify_fault_i,
  input  wire port_clock_gating_pkg::port_access_type    port_access_i,
  input  wire logic                                      regulator_lost_i,
  output logic [port_clock_gating_pkg::NUM_PORTS-1:0]    port_clk_en_o,
  output logic                                           bus_fault_o,
  output port_clock_gating_pkg::clk_src_type             clk_src_o,
  output logic                                           main_osc_pwr_o,
  output logic                                           int_osc_pwr_o,
  output logic                                           verify_clear_o,
  output logic                                           regulator_reset_o,
  output logic                                           irq_o
);
  import port_clock_gating_pkg::*;

  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------
  logic [NUM_PORTS-1:0]  run_gate_r;
  logic [NUM_PORTS-1:0]  sleep_gate_r;
  logic [NUM_PORTS-1:0]  deep_gate_r;
  logic                  auto_gate_r;
  logic                  osc_ovr_r;
  logic                  vfy_clr_r;
  logic                  reg_rst_en_r;
  logic [NUM_EVENTS-1:0] irq_stat_r;
  logic [NUM_EVENTS-1:0] irq_mask_r;
  logic [DATA_W-1:0]     rdata_r;
  logic                  fault_r;
  logic                  in_deep_r;
  clk_src_type           saved_src_r;
  logic                  vfy_active_r;
  logic                  vfy_armed_r;
  logic                  reg_lost_s1_r;
  logic                  reg_lost_s2_r;
  logic                  reg_rst_r;

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  wire hit_run   = reg_req_i.addr == RUN_GATE_OFS;
  wire hit_sleep = reg_req_i.addr == SLEEP_GATE_OFS;
  wire hit_deep  = reg_req_i.addr == DEEP_GATE_OFS;
  wire hit_src   = reg_req_i.addr == DS_SRC_OFS;
  wire hit_vfy   = reg_req_i.addr == VFY_CLR_OFS;
  wire hit_rrst  = reg_req_i.addr == REG_RST_OFS;
  wire hit_cfg   = reg_req_i.addr == RUN_CFG_OFS;
  wire hit_stat  = reg_req_i.addr == IRQ_STAT_OFS;
  wire hit_mask  = reg_req_i.addr == IRQ_MASK_OFS;
  wire wr        = reg_req_i.wr;
  wire [DATA_W-1:0] wd = reg_req_i.wdata;

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  // reserved bits fixed at zero, so writes to them are dropped
  always_comb begin
    if (hit_run) begin
      rd_mux = {{(DATA_W-NUM_PORTS){1'b0}}, run_gate_r};
    end else if (hit_sleep) begin
      rd_mux = {{(DATA_W-NUM_PORTS){1'b0}}, sleep_gate_r};
    end else if (hit_deep) begin
      rd_mux = {{(DATA_W-NUM_PORTS){1'b0}}, deep_gate_r};
    end else if (hit_src) begin
      rd_mux = {{(DATA_W-1){1'b0}}, osc_ovr_r};
    end else if (hit_vfy) begin
      rd_mux = {{(DATA_W-1){1'b0}}, vfy_clr_r};
    end else if (hit_rrst) begin
      rd_mux = {{(DATA_W-1){1'b0}}, reg_rst_en_r};
    end else if (hit_cfg) begin
      rd_mux = {{(DATA_W-1){1'b0}}, auto_gate_r};
    end else if (hit_stat) begin
      rd_mux = {{(DATA_W-NUM_EVENTS){1'b0}}, irq_stat_r};
    end else if (hit_mask) begin
      rd_mux = {{(DATA_W-NUM_EVENTS){1'b0}}, irq_mask_r};
    end else begin
      rd_mux = ZERO_WORD;
    end
  end

  // ---------------------------------------------------------------------------
  // bank selection and gating
  // ---------------------------------------------------------------------------
  logic [NUM_PORTS-1:0] active_bank;
  always_comb begin
    active_bank = run_gate_r;
    if (auto_gate_r) begin
      case (power_mode_i)
        PM_SLEEP: active_bank = sleep_gate_r;
        PM_DEEP:  active_bank = deep_gate_r;
        default:  active_bank = run_gate_r;
      endcase
    end
  end

  wire [NUM_PORTS-1:0] blocked_hit =
    port_access_i.sel & ~active_bank;
  wire access_bad =
    (port_access_i.rd | port_access_i.wr) & (|blocked_hit);

  // ---------------------------------------------------------------------------
  // deep-sleep clock source
  // ---------------------------------------------------------------------------
  wire deep_now   = power_mode_i == PM_DEEP;
  wire deep_enter = deep_now & ~in_deep_r;
  wire deep_exit  = in_deep_r & deep_wake_i;
  wire wake_ev    = deep_exit;

  clk_src_type src_sel;
  always_comb begin
    if (vfy_active_r) begin
      src_sel = SRC_BACKUP;
    end else if (in_deep_r && osc_ovr_r) begin
      src_sel = SRC_INTERNAL;
    end else if (in_deep_r) begin
      src_sel = saved_src_r;
    end else begin
      src_sel = run_src_i;
    end
  end

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_gate_r   <= GATE_RST;
      sleep_gate_r <= GATE_RST;
      deep_gate_r  <= GATE_RST;
      auto_gate_r  <= 1'b0;
      osc_ovr_r    <= 1'b0;
      vfy_clr_r    <= 1'b0;
      reg_rst_en_r <= 1'b0;
      irq_mask_r   <= '0;
    end else begin
      if (wr && hit_run)   run_gate_r   <= wd[NUM_PORTS-1:0];
      if (wr && hit_sleep) sleep_gate_r <= wd[NUM_PORTS-1:0];
      if (wr && hit_deep)  deep_gate_r  <= wd[NUM_PORTS-1:0];
      if (wr && hit_cfg)   auto_gate_r  <= wd[AUTO_GATE_BIT];
      if (wr && hit_src)   osc_ovr_r    <= wd[OSC_OVR_BIT];
      if (wr && hit_vfy)   vfy_clr_r    <= wd[VFY_CLR_BIT];
      if (wr && hit_rrst)  reg_rst_en_r <= wd[REG_RST_BIT];
      if (wr && hit_mask)  irq_mask_r   <= wd[NUM_EVENTS-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // status, fault and clock state
  // ---------------------------------------------------------------------------
  wire [NUM_EVENTS-1:0] ev_set;
  assign ev_set[EV_FAULT]  = access_bad;
  assign ev_set[EV_VERIFY] = verify_fault_i & ~vfy_active_r;
  assign ev_set[EV_WAKE]   = wake_ev;
  wire [NUM_EVENTS-1:0] ev_clr =
    (wr && hit_stat) ? wd[NUM_EVENTS-1:0] : '0;

  // clearing needs the one-then-zero sequence; a held one does not keep
  // re-clearing a fault that returns later
  wire vfy_release = vfy_armed_r & ~vfy_clr_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r      <= ZERO_WORD;
      fault_r      <= 1'b0;
      irq_stat_r   <= '0;
      in_deep_r    <= 1'b0;
      saved_src_r  <= SRC_MAIN;
      vfy_active_r <= 1'b0;
      vfy_armed_r  <= 1'b0;
    end else begin
      rdata_r    <= reg_req_i.rd ? rd_mux : ZERO_WORD;
      fault_r    <= access_bad;
      irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_set;  // set wins over clear
      if (deep_enter) begin
        in_deep_r   <= 1'b1;
        saved_src_r <= run_src_i;
      end else if (deep_exit) begin
        in_deep_r   <= 1'b0;
      end
      vfy_armed_r <= vfy_clr_r;
      if (verify_fault_i) begin
        vfy_active_r <= 1'b1;
      end else if (vfy_release) begin
        vfy_active_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // regulator loss: analog pin, synchronised before use
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_lost_s1_r <= 1'b0;
      reg_lost_s2_r <= 1'b0;
      reg_rst_r     <= 1'b0;
    end else begin
      reg_lost_s1_r <= regulator_lost_i;
      reg_lost_s2_r <= reg_lost_s1_r;
      reg_rst_r     <= reg_lost_s2_r & reg_rst_en_r;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign port_clk_en_o     = active_bank;
  assign bus_fault_o       = fault_r;
  assign reg_rdata_o       = rdata_r;
  assign clk_src_o         = src_sel;
  assign int_osc_pwr_o     = src_sel == SRC_INTERNAL;
  assign main_osc_pwr_o    = src_sel != SRC_INTERNAL;
  assign verify_clear_o    = vfy_clr_r;
  assign regulator_reset_o = reg_rst_r;
  assign irq_o             = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_fault_on_gated: assert property (
    access_bad |=> bus_fault_o)
    else $error("gated port access gave no bus fault");
  chk_run_bank_only: assert property (
    !auto_gate_r |-> port_clk_en_o == run_gate_r)
    else $error("non-run bank used without auto gating");
  chk_deep_bank_used: assert property (
    auto_gate_r && power_mode_i == PM_DEEP |-> port_clk_en_o == deep_gate_r)
    else $error("deep bank not applied");
  chk_write_run_bank: assert property (
    wr && hit_run |=> run_gate_r == $past(wd[NUM_PORTS-1:0]))
    else $error("run bank write lost");
  chk_reserved_zero: assert property (
    $past(reg_req_i.rd) && $past(hit_run)
      |-> reg_rdata_o[DATA_W-1:NUM_PORTS] == '0)
    else $error("reserved bits not zero");
  chk_ovr_internal: assert property (
    in_deep_r && osc_ovr_r && !vfy_active_r
      |-> clk_src_o == SRC_INTERNAL && !main_osc_pwr_o)
    else $error("override did not pick internal oscillator");
  chk_restore_src: assert property (
    deep_enter ##1 (in_deep_r && !deep_exit)[*1] ##1 deep_exit
      ##1 !vfy_active_r |-> clk_src_o == run_src_i)
    else $error("source not restored");
  // without override the entry source stands, so pin it when that was main
  chk_main_kept: assert property (
    in_deep_r && !osc_ovr_r && !vfy_active_r && saved_src_r == SRC_MAIN
      |-> clk_src_o == SRC_MAIN && main_osc_pwr_o && !int_osc_pwr_o)
    else $error("main oscillator dropped without override");
  chk_backup_clock: assert property (
    verify_fault_i |=> clk_src_o == SRC_BACKUP)
    else $error("no backup clock on verify fault");
  chk_clear_sticky: assert property (
    !(wr && hit_vfy) |=> vfy_clr_r == $past(vfy_clr_r))
    else $error("verify clear changed on its own");
  chk_regulator_rst: assert property (
    !reg_rst_en_r ##1 !reg_rst_en_r |-> !regulator_reset_o)
    else $error("regulator reset while disabled");

  cov_gated_fault: cover property (access_bad ##1 bus_fault_o);
  cov_deep_cycle:  cover property (deep_enter ##[1:20] deep_exit);
  cov_verify_clr:  cover property (vfy_active_r ##1 vfy_release);
  cov_irq:         cover property (irq_o);

endmodule : port_clock_gating_sysctl

// [dv/port_clock_gating_sysctl_tb_top.sv]
// self-checking bench for the port clock gating system-control slice
// assumes the design package is compiled first; the bench drives every port
`timescale 1ns/1ps

module port_clock_gating_sysctl_tb_top;
  import port_clock_gating_pkg::*;

  logic                 sys_clk_i = 1'b0;
  logic                 reset_n_i = 1'b0;
  reg_req_type          req       = '0;
  power_mode_type       mode      = PM_RUN;
  clk_src_type          src       = SRC_MAIN;
  port_access_type      acc       = '0;
  logic                 wake      = 1'b0;
  logic                 vfault    = 1'b0;
  logic                 lost      = 1'b0;
  logic [DATA_W-1:0]    rdata;
  logic [NUM_PORTS-1:0] en;
  logic                 bfault, mpwr, ipwr, vclr, rrst, irq;
  clk_src_type          csrc;
  int                   n_fail = 0;
  int                   comparisons = 0;
  int                   cycles = 0;
  logic [31:0]          seed = 32'h0000_9d10;

  port_clock_gating_sysctl DUT (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .power_mode_i(mode), .deep_wake_i(wake),
    .run_src_i(src), .verify_fault_i(vfault), .port_access_i(acc),
    .regulator_lost_i(lost), .port_clk_en_o(en), .bus_fault_o(bfault),
    .clk_src_o(csrc), .main_osc_pwr_o(mpwr), .int_osc_pwr_o(ipwr),
    .verify_clear_o(vclr), .regulator_reset_o(rrst), .irq_o(irq));

  always #2 sys_clk_i = ~sys_clk_i;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // banks other than run matter only with auto gating in a sleep mode
  function automatic logic [4:0] exp_en(power_mode_type m, logic a,
                                        logic [4:0] r, s, d);
    if (!a || m == PM_RUN) return r;
    if (m == PM_SLEEP) return s;
    return d;
  endfunction : exp_en

  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1 chk(rdata, e, "read data");
  endtask : rd

  task automatic access(input logic [5:0] p, input logic e);
    @(posedge sys_clk_i);
    acc <= '{p[4:0], p[5], ~p[5]};
    @(posedge sys_clk_i);
    acc <= '0;
    #1 chk(bfault, e, "bus fault");
  endtask : access

  task automatic wake_up();
    @(posedge sys_clk_i);
    wake <= 1'b1;
    @(posedge sys_clk_i);
    wake <= 1'b0;
    mode <= PM_RUN;
    @(posedge sys_clk_i);
    #1;
  endtask : wake_up

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [11:0]    ofs [9];
    power_mode_type modes [3];
    logic [31:0]    r, s, d, a, p;
    logic [4:0]     e;
    ofs = '{RUN_GATE_OFS, SLEEP_GATE_OFS, DEEP_GATE_OFS, DS_SRC_OFS,
            VFY_CLR_OFS, REG_RST_OFS, RUN_CFG_OFS, IRQ_STAT_OFS,
            IRQ_MASK_OFS};
    modes = '{PM_RUN, PM_SLEEP, PM_DEEP};
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    #1 chk(en, 32'h0, "enables at reset");
    chk(irq, 32'h0, "irq at reset");
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    wr(12'h200, rnd());
    rd(12'h200, 32'h0);
    wr(RUN_GATE_OFS, 32'hffff_ffe0);
    rd(RUN_GATE_OFS, 32'h0);
    // random banks, auto gating and power mode
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      s = rnd();
      d = rnd();
      a = rnd();
      p = rnd();
      wr(RUN_CFG_OFS, {31'h0, a[0]});
      wr(RUN_GATE_OFS, r);
      wr(SLEEP_GATE_OFS, s);
      wr(DEEP_GATE_OFS, d);
      @(posedge sys_clk_i);
      mode <= modes[p[9:8] % 3];
      @(posedge sys_clk_i);
      e = exp_en(mode, a[0], r[4:0], s[4:0], d[4:0]);
      #1 chk(en, e, "port enables");
      rd(RUN_GATE_OFS, r & 32'h1f);
      rd(SLEEP_GATE_OFS, s & 32'h1f);
      rd(DEEP_GATE_OFS, d & 32'h1f);
      access(p[5:0], |(p[4:0] & ~e));
    end
    @(posedge sys_clk_i);
    mode <= PM_DEEP;
    wake_up();
    // bus fault interrupt: masked, unmasked, cleared
    wr(RUN_CFG_OFS, 32'h0);
    wr(RUN_GATE_OFS, 32'h0);
    wr(IRQ_STAT_OFS, 32'h7);
    wr(IRQ_MASK_OFS, 32'h0);
    access(6'h21, 1'b1);
    chk(irq, 32'h0, "masked irq");
    rd(IRQ_STAT_OFS, 32'h1);
    wr(IRQ_MASK_OFS, 32'h1);
    #1 chk(irq, 32'h1, "irq raised");
    wr(IRQ_STAT_OFS, 32'h1);
    #1 chk(irq, 32'h0, "irq cleared");
    // source at entry is kept through deep-sleep without override
    @(posedge sys_clk_i);
    src <= SRC_INTERNAL;
    mode <= PM_DEEP;
    @(posedge sys_clk_i);
    src <= SRC_MAIN;
    @(posedge sys_clk_i);
    #1 chk(csrc, SRC_INTERNAL, "deep source kept");
    wake_up();
    chk(csrc, SRC_MAIN, "source after wake");
    rd(IRQ_STAT_OFS, 32'h4);
    wr(DS_SRC_OFS, 32'hffff_ffff);
    rd(DS_SRC_OFS, 32'h1);
    @(posedge sys_clk_i);
    mode <= PM_DEEP;
    @(posedge sys_clk_i);
    #1 chk(csrc, SRC_INTERNAL, "override source");
    chk({mpwr, ipwr}, 32'h1, "oscillator power");
    wake_up();
    chk(csrc, SRC_MAIN, "restored source");
    chk(mpwr, 32'h1, "main osc on");
    // verification fault holds the backup clock until cleared
    @(posedge sys_clk_i);
    vfault <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 chk(csrc, SRC_BACKUP, "backup clock");
    @(posedge sys_clk_i);
    vfault <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 chk(csrc, SRC_BACKUP, "backup held");
    wr(VFY_CLR_OFS, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    #1 chk(vclr, 32'h1, "clear bit held");
    chk(csrc, SRC_BACKUP, "backup until zero");
    wr(VFY_CLR_OFS, 32'h0);
    @(posedge sys_clk_i);
    #1 chk(csrc, SRC_MAIN, "fault released");
    rd(VFY_CLR_OFS, 32'h0);
    // regulator loss resets only when enabled
    @(posedge sys_clk_i);
    lost <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1 chk(rrst, 32'h0, "reset disabled");
    wr(REG_RST_OFS, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    #1 chk(rrst, 32'h1, "reset enabled");
    @(posedge sys_clk_i);
    lost <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1 chk(rrst, 32'h0, "reset dropped");
    rd(REG_RST_OFS, 32'h1);
    test_done();
  end

endmodule : port_clock_gating_sysctl_tb_top
